// ---- inc/scp_pkg.sv ----
// Shared constants and a helper function for the serial configuration port
package scp_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ     = 200;
    localparam int SCLK_MAX_MHZ    = 40;
    // Half period of the generated serial clock; far end syncs and
    // registered pins need eight cycles to turn round, well under 40 MHz
    localparam int SCLK_HALF_CYC   = 8;
    localparam int RESYNC_EDGES    = 8;
    localparam int INSTR_BITS      = 8;

    // ------------------------------------------------------------
    // Instruction byte layout
    // ------------------------------------------------------------
    localparam int INSTR_RW_BIT    = 7;
    localparam int INSTR_ADDR_MSB  = 4;
    localparam int ADDR_W          = 5;
    localparam int MAX_BYTES       = 4;
    localparam int DATA_W          = 32;

    // ------------------------------------------------------------
    // Port configuration register
    // ------------------------------------------------------------
    localparam logic [4:0] CFG_ADDR      = 5'h00;
    localparam int         CFG_3WIRE_BIT = 7;
    localparam int         CFG_LSBF_BIT  = 6;
    localparam logic [7:0] CFG_RESET     = 8'h02;

    // ------------------------------------------------------------
    // Host APB register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_WDATA  = 8'h04;
    localparam logic [7:0] REG_RDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_MODE   = 8'h10;
    // Command and mode register fields
    localparam int CMD_RW_BIT   = 7;
    localparam int CMD_LEN_LSB  = 8;
    localparam int CMD_GO_BIT   = 16;
    localparam int CMD_SYNC_BIT = 17;
    localparam int MODE_3W_BIT  = 0;
    localparam int MODE_LSB_BIT = 1;

    // Register width in bytes for each address (map contents left out)
    function automatic logic [2:0] scp_reg_bytes(input logic [4:0] a);
        case (a)
            5'h00:   scp_reg_bytes = 3'h1;
            5'h01,
            5'h02:   scp_reg_bytes = 3'h2;
            5'h03:   scp_reg_bytes = 3'h4;
            5'h04:   scp_reg_bytes = 3'h3;
            default: scp_reg_bytes = 3'h2;
        endcase
    endfunction : scp_reg_bytes

endpackage : scp_pkg

// ---- inc/scp_if.sv ----
// Serial link between host controller and configuration port
`timescale 1ns/10ps
interface scp_if;
    logic sclk;
    logic cs_n;
    logic sdio_o_host;
    logic sdio_oe_n_host;
    logic sdio_o_dev;
    logic sdio_oe_n_dev;
    logic serial_data_out;
    logic serial_data_out_oe_n;
    wire  sdio;

    assign sdio = !sdio_oe_n_host ? sdio_o_host :
                  !sdio_oe_n_dev  ? sdio_o_dev  : 1'b1;

    modport dev (
        input  sclk, cs_n, sdio,
        output sdio_o_dev, sdio_oe_n_dev,
        output serial_data_out, serial_data_out_oe_n
    );
    modport host (
        output sclk, cs_n, sdio_o_host, sdio_oe_n_host,
        input  sdio, serial_data_out, serial_data_out_oe_n
    );
endinterface : scp_if

// ---- core/scp_sync.sv ----
// Two-stage synchroniser with edge detection on the second stage
`timescale 1ns/10ps
module scp_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic d,
    output logic      q,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            q    <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
            prev <= q;
        end
    end

    assign rise = q & ~prev;
    assign fall = ~q & prev;
endmodule : scp_sync

// ---- core/scp_device.sv ----
// Device end: instruction decode, data phase and configuration store
//
// Chosen here: the register addresses and the write-strobe and read-address interface to the registers.
`timescale 1ns/10ps
module scp_device
    import scp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    scp_if.dev               link,
    output logic [DATA_W-1:0] wr_data,
    output logic [ADDR_W-1:0] wr_addr,
    output logic             wr_strobe,
    input  wire logic [DATA_W-1:0] rd_data,
    output logic [ADDR_W-1:0] rd_addr,
    output logic [7:0]       cfg
);
    typedef enum logic [1:0] {SCP_INSTR, SCP_DATA} scp_dstate_t;

    logic        sclk_s, sclk_rise, sclk_fall;
    logic        cs_s, sdi_s;
    scp_dstate_t state;
    logic [7:0]  instr;
    logic [5:0]  bitcnt;
    logic [5:0]  total_bits;
    logic [DATA_W-1:0] shreg;
    logic [3:0]  resync_cnt;
    logic        out_bit;
    logic        dv;
    logic        dummy_r, dummy_f;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    scp_sync u_sclk (.pclk(pclk), .presetn(presetn), .d(link.sclk),
                     .q(sclk_s), .rise(sclk_rise), .fall(sclk_fall));
    scp_sync u_cs   (.pclk(pclk), .presetn(presetn), .d(link.cs_n),
                     .q(cs_s), .rise(dummy_r), .fall(dummy_f));
    scp_sync u_sdi  (.pclk(pclk), .presetn(presetn), .d(link.sdio),
                     .q(sdi_s), .rise(), .fall());

    wire lsbf      = cfg[CFG_LSBF_BIT];
    wire three_w   = cfg[CFG_3WIRE_BIT];
    wire [4:0] adr = instr[INSTR_ADDR_MSB:0];
    wire is_read   = instr[INSTR_RW_BIT];
    wire active    = !cs_s;
    wire do_rise   = active && sclk_rise;
    wire [7:0] next_instr = lsbf ? {sdi_s, instr[7:1]}
                                 : {instr[6:0], sdi_s};
    wire [2:0] nbytes = scp_reg_bytes(next_instr[4:0]);

    // ------------------------------------------------------------
    // Resynchronisation counter
    // ------------------------------------------------------------
    wire resync = cs_s && sclk_rise && (resync_cnt == 4'(RESYNC_EDGES-1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resync_cnt <= 4'h0;
        end else if (!cs_s) begin
            resync_cnt <= 4'h0;
        end else if (sclk_rise && resync_cnt != 4'(RESYNC_EDGES)) begin
            resync_cnt <= resync_cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= SCP_INSTR;
            instr      <= 8'h00;
            bitcnt     <= 6'h0;
            total_bits <= 6'h0;
            shreg      <= '0;
            wr_strobe  <= 1'b0;
            wr_data    <= '0;
            wr_addr    <= '0;
            rd_addr    <= '0;
        end else begin
            wr_strobe <= 1'b0;
            if (resync) begin
                state  <= SCP_INSTR;
                bitcnt <= 6'h0;
            end else if (do_rise) begin
                case (state)
                    SCP_INSTR: begin
                        instr <= next_instr;
                        if (bitcnt == 6'(INSTR_BITS-1)) begin
                            state      <= SCP_DATA;
                            bitcnt     <= 6'h0;
                            total_bits <= {nbytes, 3'b000};
                            rd_addr    <= next_instr[4:0];
                            shreg      <= '0;
                        end else begin
                            bitcnt <= bitcnt + 6'h1;
                        end
                    end
                    SCP_DATA: begin
                        shreg <= lsbf ? {sdi_s, shreg[DATA_W-1:1]}
                                      : {shreg[DATA_W-2:0], sdi_s};
                        if (bitcnt == total_bits - 6'h1) begin
                            state  <= SCP_INSTR;
                            bitcnt <= 6'h0;
                            if (!is_read) begin
                                wr_strobe <= 1'b1;
                                wr_addr   <= adr;
                                wr_data   <= lsbf
                                    ? ({sdi_s, shreg[DATA_W-1:1]}
                                       >> (6'(DATA_W) - total_bits))
                                    : {shreg[DATA_W-2:0], sdi_s};
                            end
                        end else begin
                            bitcnt <= bitcnt + 6'h1;
                        end
                    end
                    default: state <= SCP_INSTR;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Port configuration register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= CFG_RESET;
        end else if (wr_strobe && wr_addr == CFG_ADDR) begin
            cfg <= wr_data[7:0];
        end
    end

    // ------------------------------------------------------------
    // Read data launch on falling edges
    // ------------------------------------------------------------
    wire [5:0] pos   = lsbf ? bitcnt : (total_bits - 6'h1 - bitcnt);
    wire [DATA_W-1:0] rd_word = (rd_addr == CFG_ADDR) ? {24'h0, cfg}
                                                       : rd_data;
    wire reading = active && state == SCP_DATA && is_read;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_bit <= 1'b0;
        end else if (reading && sclk_fall) begin
            out_bit <= rd_word[pos[4:0]];
        end
    end

    // Drive only after the first falling edge, once the host let go
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dv <= 1'b0;
        end else begin
            dv <= reading && (dv || sclk_fall);
        end
    end

    // ------------------------------------------------------------
    // Pin drivers: low enable drives the pin
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.sdio_oe_n_dev        <= 1'b1;
            link.serial_data_out_oe_n <= 1'b1;
            link.sdio_o_dev           <= 1'b0;
            link.serial_data_out      <= 1'b0;
        end else begin
            link.sdio_o_dev           <= out_bit;
            link.serial_data_out      <= out_bit;
            link.sdio_oe_n_dev        <= !(dv && three_w);
            link.serial_data_out_oe_n <= !(dv && !three_w);
        end
    end
endmodule : scp_device

// ---- core/scp_host.sv ----
// Host end: APB register slave driving the serial link
`timescale 1ns/10ps
module scp_host
    import scp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    scp_if.host              link
);
    typedef enum logic [1:0] {SCH_IDLE, SCH_SHIFT, SCH_SYNC} scp_hstate_t;

    scp_hstate_t state;
    logic [31:0] cmd, wdata, rdata;
    logic [1:0]  mode;
    logic [5:0]  nbits, bitcnt;
    logic [3:0]  div;
    logic        sdi_s, sdo_s;
    logic [7:0]  instr;

    scp_sync u_sdio (.pclk(pclk), .presetn(presetn), .d(link.sdio),
                     .q(sdi_s), .rise(), .fall());
    scp_sync u_sdo  (.pclk(pclk), .presetn(presetn),
                     .d(link.serial_data_out), .q(sdo_s), .rise(), .fall());

    wire acc   = psel && penable;
    wire busy  = state != SCH_IDLE;
    wire tick  = div == 4'(SCLK_HALF_CYC-1);
    wire lsbf  = mode[MODE_LSB_BIT];
    wire rx    = mode[MODE_3W_BIT] ? sdi_s : sdo_s;

    // ------------------------------------------------------------
    // APB slave, one wait-free access phase
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && !pready;
            pslverr <= psel && !pready && !(paddr inside
                {REG_CMD, REG_WDATA, REG_RDATA, REG_STATUS, REG_MODE});
            case (paddr)
                REG_CMD:    prdata <= cmd;
                REG_WDATA:  prdata <= wdata;
                REG_RDATA:  prdata <= rdata;
                REG_STATUS: prdata <= {31'h0, busy};
                REG_MODE:   prdata <= {30'h0, mode};
                default:    prdata <= 32'h0;
            endcase
        end
    end

    wire wr    = acc && pready && pwrite;
    wire go    = wr && paddr == REG_CMD && !busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd   <= 32'h0;
            wdata <= 32'h0;
            mode  <= 2'h0;
        end else begin
            if (go) cmd <= pwdata;
            if (wr && paddr == REG_WDATA) wdata <= pwdata;
            if (wr && paddr == REG_MODE) mode <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Serial engine: host clock idles low
    // ------------------------------------------------------------
    wire [5:0] nxt  = bitcnt + 6'h1;
    wire [5:0] pos  = lsbf ? bitcnt - 6'd8 : nbits + 6'd7 - bitcnt;
    wire [5:0] npos = lsbf ? nxt - 6'd8 : nbits + 6'd7 - nxt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state              <= SCH_IDLE;
            div                <= 4'h0;
            bitcnt             <= 6'h0;
            nbits              <= 6'h0;
            rdata              <= 32'h0;
            instr              <= 8'h00;
            link.sclk          <= 1'b0;
            link.cs_n          <= 1'b1;
            link.sdio_o_host   <= 1'b0;
            link.sdio_oe_n_host <= 1'b1;
        end else begin
            div <= tick ? 4'h0 : div + 4'h1;
            case (state)
                SCH_IDLE: if (go) begin
                    bitcnt <= 6'h0;
                    instr  <= pwdata[7:0];
                    link.sdio_oe_n_host <= pwdata[CMD_SYNC_BIT];
                    link.sdio_o_host <= lsbf ? pwdata[0]
                                             : pwdata[CMD_RW_BIT];
                    nbits  <= {pwdata[CMD_LEN_LSB+2:CMD_LEN_LSB], 3'b000};
                    rdata  <= 32'h0;
                    div    <= 4'h0;
                    state  <= pwdata[CMD_SYNC_BIT] ? SCH_SYNC : SCH_SHIFT;
                    link.cs_n <= pwdata[CMD_SYNC_BIT];
                end
                SCH_SHIFT, SCH_SYNC: if (tick) begin
                    if (!link.sclk) begin
                        link.sclk <= 1'b1;
                        if (state == SCH_SHIFT && bitcnt >= 6'd8 && instr[7])
                            rdata[pos[4:0]] <= rx;
                    end else begin
                        link.sclk <= 1'b0;
                        bitcnt    <= nxt;
                        if (state == SCH_SHIFT) begin
                            link.sdio_oe_n_host <= !(nxt < 6'd8 || !instr[7]);
                            link.sdio_o_host <= nxt < 6'd8
                                ? instr[lsbf ? nxt[2:0] : 3'(7 - nxt[2:0])]
                                : wdata[npos[4:0]];
                        end
                        if (bitcnt == (state == SCH_SYNC ? 6'd7
                                        : nbits + 6'd7)) begin
                            state               <= SCH_IDLE;
                            link.cs_n           <= 1'b1;
                            link.sdio_oe_n_host <= 1'b1;
                        end
                    end
                end
                default: state <= SCH_IDLE;
            endcase
        end
    end
endmodule : scp_host

// ---- tb/scp_link_checker.sv ----
// Link checker watching both ends of the serial configuration port
`timescale 1ns/10ps
module scp_link_checker (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic sdio_o_host,
    input  wire logic sdio_oe_n_host,
    input  wire logic sdio_o_dev,
    input  wire logic sdio_oe_n_dev,
    input  wire logic serial_data_out,
    input  wire logic serial_data_out_oe_n
);
    logic       sclk_q;
    logic       cs_q;
    logic [7:0] n_rise;

    // Count kept after frame end, so late releases still see it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
            n_rise <= 8'h00;
        end else begin
            sclk_q <= sclk;
            cs_q   <= cs_n;
            if (cs_q && !cs_n) begin
                n_rise <= 8'h00;
            end else if (!cs_n && sclk && !sclk_q) begin
                n_rise <= n_rise + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_frame_end;
        cs_n && !cs_q;
    endsequence
    sequence s_dev_drive;
        !sdio_oe_n_dev || !serial_data_out_oe_n;
    endsequence

    property p_frame_len;
        s_frame_end |-> n_rise inside {8'h10, 8'h18, 8'h20, 8'h28};
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("bad length");
    property p_instr_first;
        s_dev_drive |-> n_rise >= 8'h08;
    endproperty
    a_instr_first: assert property (p_instr_first) else $error("early");
    property p_idle_release;
        cs_n [*4] |-> sdio_oe_n_dev && serial_data_out_oe_n;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("held");
    property p_one_pin;
        s_dev_drive |-> sdio_oe_n_dev || serial_data_out_oe_n;
    endproperty
    a_one_pin: assert property (p_one_pin) else $error("two pins");
    property p_no_fight;
        !sdio_oe_n_dev |-> sdio_oe_n_host;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("contention");
    property p_host_drive;
        !cs_n && !cs_q && n_rise < 8'h08 |-> !sdio_oe_n_host;
    endproperty
    a_host_drive: assert property (p_host_drive) else $error("undriven");
    property p_host_edge;
        $changed(sdio_o_host) && !sdio_oe_n_host && !cs_n |-> !sclk;
    endproperty
    a_host_edge: assert property (p_host_edge) else $error("host edge");
    property p_dev_edge;
        $changed(sdio_o_dev) && !sdio_oe_n_dev && !$past(sdio_oe_n_dev)
            |-> !sclk || !$past(sclk);
    endproperty
    a_dev_edge: assert property (p_dev_edge) else $error("dev edge");
endmodule : scp_link_checker

// ---- tb/tb.sv ----
// Testbench joining host and device ends of the serial port
`timescale 1ns/10ps
module tb
    import scp_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd_data = 32'h0;
    logic [31:0] prdata, wr_data, wr_data2, wd, wd2;
    logic [4:0]  wr_addr, wr_addr2, rd_addr, rd_addr2, wa, wa2;
    logic        pready, pslverr, wr_strobe, wr_strobe2;
    logic        md3, lsb, sclk_p, cs_p;
    logic [7:0]  cfg, cfg_exp;
    logic [47:0] cap;
    int          n_fail, total_checks, n_wr, n_wr2, sdo_bad, ncap;

    scp_if link();
    scp_if link2();
    scp_host scp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    scp_device scp_device_inst (.pclk(pclk), .presetn(presetn), .link(link),
        .wr_data(wr_data), .wr_addr(wr_addr), .wr_strobe(wr_strobe),
        .rd_data(rd_data), .rd_addr(rd_addr), .cfg(cfg));
    // Second device faces the bench driver for rule-breaking host traffic
    scp_device scp_device_inst2 (.pclk(pclk), .presetn(presetn),
        .link(link2), .wr_data(wr_data2), .wr_addr(wr_addr2),
        .wr_strobe(wr_strobe2), .rd_data(32'h0), .rd_addr(rd_addr2), .cfg());
    scp_link_checker scp_link_checker_inst (.pclk(pclk), .presetn(presetn),
        .sclk(link.sclk), .cs_n(link.cs_n), .sdio_o_host(link.sdio_o_host),
        .sdio_oe_n_host(link.sdio_oe_n_host), .sdio_o_dev(link.sdio_o_dev),
        .sdio_oe_n_dev(link.sdio_oe_n_dev),
        .serial_data_out(link.serial_data_out),
        .serial_data_out_oe_n(link.serial_data_out_oe_n));

    always #2.5 pclk = ~pclk;

    function automatic logic [31:0] pat(input logic [4:0] a);
        return {3'h5, a, 3'h6, a, 3'h3, a, 3'h1, a};
    endfunction : pat
    function automatic logic [47:0] msk(input logic [2:0] nb);
        return (48'h1 << (8 * nb)) - 48'h1;
    endfunction : msk
    function automatic logic [47:0] ser(input logic [7:0] ins,
                                        input logic [31:0] d,
                                        input logic [2:0] nb);
        logic [47:0] v;
        logic [47:0] r;
        int          w;
        w = 8 + 8 * nb;
        if (!lsb) return ({40'h0, ins} << (8 * nb)) | ({16'h0, d} & msk(nb));
        v = (({16'h0, d} & msk(nb)) << 8) | {40'h0, ins};
        r = 48'h0;
        for (int i = 0; i < w; i++) r[w - 1 - i] = v[i];
        return r;
    endfunction : ser

    // ------------------------------------------------------------
    // Monitors
    // ------------------------------------------------------------
    // Wire bits taken one edge after sclk rise, once both ends settled
    always @(posedge pclk) begin
        rd_data <= pat(rd_addr);
        if (wr_strobe === 1'b1) begin
            n_wr++;
            wa = wr_addr;
            wd = wr_data;
        end
        if (wr_strobe2 === 1'b1) begin
            n_wr2++;
            wa2 = wr_addr2;
            wd2 = wr_data2;
        end
        if (md3 && link.serial_data_out_oe_n !== 1'b1) sdo_bad++;
        if (!link.cs_n && cs_p) ncap = 0;
        if (!link.cs_n && link.sclk && !sclk_p) begin
            cap = {cap[46:0], (md3 || ncap < 8 || !cap[ncap - 1]) ? link.sdio
                                                 : link.serial_data_out};
            ncap++;
        end
        sclk_p = link.sclk;
        cs_p = link.cs_n;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [47:0] e,
                       input logic [47:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) n_fail++;
    endtask : apb

    task automatic xfer(input logic [7:0] ins, input logic [31:0] d,
                        input logic [31:0] ed, input logic [2:0] nb,
                        output logic [31:0] rd);
        logic [31:0] st;
        logic        er;
        int          k;
        apb(1'b1, REG_WDATA, d, st, er);
        apb(1'b1, REG_CMD, {14'h0, 2'b01, 5'h00, nb, ins}, st, er);
        k = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0, st, er);
            k++;
        end while (st[0] !== 1'b0 && k < 400);
        apb(1'b0, REG_RDATA, 32'h0, rd, er);
        chk("frame", ser(ins, ed, nb), cap & ((msk(nb) << 8) | 48'hff));
    endtask : xfer

    // Link period 65 ns, nearest to 64 ns on the 5 ns grid
    task automatic bb(input logic cs, input logic b);
        link2.cs_n <= cs;
        link2.sdio_oe_n_host <= cs;
        link2.sdio_o_host <= b;
        repeat (6) @(posedge pclk);
        link2.sclk <= 1'b1;
        repeat (7) @(posedge pclk);
        link2.sclk <= 1'b0;
    endtask : bb
    task automatic bb_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) bb(1'b0, v[i]);
    endtask : bb_byte

    task automatic t_reset();
        logic [31:0] rd;
        logic        er;
        chk("cfg_reset", CFG_RESET, cfg);
        chk("idle", 3'h7, {link.cs_n, link.sdio_oe_n_dev,
                           link.serial_data_out_oe_n});
        apb(1'b0, 8'h40, 32'h0, rd, er);
        chk("unmapped", {15'h0, 1'b1, 32'h0}, {15'h0, er, rd});
    endtask : t_reset

    task automatic t_write();
        logic [4:0]  ad [5] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h1f};
        logic [2:0]  nb [5] = '{3'h2, 3'h2, 3'h4, 3'h3, 3'h2};
        logic [31:0] d;
        logic [31:0] rd;
        int          n0;
        for (int i = 0; i < 5; i++) begin
            d = 32'h9ab1c2d3 + 32'h01234567 * i;
            n0 = n_wr;
            xfer({1'b0, 2'(i), ad[i]}, d, d, nb[i], rd);
            chk("wr_count", n0 + 1, n_wr);
            chk("wr_addr", ad[i], wa);
            chk("wr_data", {16'h0, d} & msk(nb[i]), {16'h0, wd} & msk(nb[i]));
        end
    endtask : t_write

    task automatic t_read();
        logic [4:0]  ad [5] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h1f};
        logic [2:0]  nb [5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h2};
        logic [31:0] e;
        logic [31:0] rd;
        int          n0;
        for (int i = 0; i < 5; i++) begin
            e = (ad[i] == 5'h00) ? {24'h0, cfg_exp}
                                 : pat(ad[i]) & 32'(msk(nb[i]));
            n0 = n_wr;
            xfer({1'b1, 2'(3 - i), ad[i]}, 32'h0, e, nb[i], rd);
            chk("rdata", e, {16'h0, rd} & msk(nb[i]));
            chk("rd_nowrite", n0, n_wr);
        end
        chk("sdo_3w", 0, sdo_bad);
    endtask : t_read

    task automatic t_mode();
        logic [31:0] rd;
        logic        er;
        xfer(8'h00, 32'hc2, 32'hc2, 3'h1, rd);
        chk("cfg", 8'hc2, cfg);
        cfg_exp = 8'hc2;
        apb(1'b1, REG_MODE, 32'h3, rd, er);
        md3 = 1'b1;
        lsb = 1'b1;
    endtask : t_mode

    // Stray bits, resync, then a write split by a select-high pause
    task automatic t_resync();
        int n0;
        n0 = n_wr2;
        repeat (3) bb(1'b0, 1'b1);
        repeat (8) bb(1'b1, 1'b0);
        bb_byte(8'h61);
        bb_byte(8'ha5);
        link2.cs_n <= 1'b1;
        link2.sdio_oe_n_host <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("oe_pause", 2'h3, {link2.sdio_oe_n_dev,
                               link2.serial_data_out_oe_n});
        chk("no_early_wr", n0, n_wr2);
        bb_byte(8'h3c);
        link2.cs_n <= 1'b1;
        link2.sdio_oe_n_host <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("resync_wr", {n0 + 1, 16'ha53c}, {n_wr2, wd2[15:0]});
        chk("resync_addr", 5'h01, wa2);
    endtask : t_resync

    task close_out();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    initial begin
        md3 = 1'b0;
        lsb = 1'b0;
        cfg_exp = CFG_RESET;
        cap = 48'h0;
        sclk_p = 1'b0;
        cs_p = 1'b1;
        link2.sclk = 1'b0;
        link2.cs_n = 1'b1;
        link2.sdio_o_host = 1'b0;
        link2.sdio_oe_n_host = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_write();
        t_read();
        t_mode();
        t_write();
        t_read();
        t_resync();
        close_out();
    end

    initial begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        close_out();
    end
endmodule : tb
